// ==== hdl/ext_bus_regs.vh ====
// Register offsets, field positions, reset values and timing counts
// for the external program memory bus. Included by the bus module only.
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH

// APB byte offsets
`define CFG_OFS        12'h000
`define STAT_OFS       12'h004

// Bus configuration register fields
`define CFG_RESET      8'h00
`define CFG_MASK       8'hb3
`define CFG_OFF_BIT    7
`define CFG_WAIT_HI    5
`define CFG_WAIT_LO    4
`define CFG_STYLE_HI   1
`define CFG_STYLE_LO   0

// Table write styles
`define STYLE_BYTE_WR  2'h0
`define STYLE_BYTE_SEL 2'h1

// Status register fields
`define STAT_PORT_BIT  0
`define STAT_BUSY_BIT  1
`define STAT_OFF_BIT   2
`define STAT_MODE_LO   4

// Program memory modes from the configuration bits
`define MODE_MPU       2'h0
`define MODE_BOOT      2'h1
`define MODE_EXT_MCU   2'h2
`define MODE_MCU       2'h3

// Request kinds
`define KIND_FETCH     2'h0
`define KIND_TRD       2'h1
`define KIND_TWR       2'h2

// Pin synchroniser depth, also the read data latency in cycles
`define SYNC_LAT       4'h3

`endif

// ==== hdl/external_program_memory_bus.v ====
// External program memory bus: APB config slave, bus cycle sequencer
// and pin function select for the shared address/data/control pins.
// Assumes one 25 MHz clock, core requests on that clock, and port
// logic outside that takes the pins whenever PORT_MODE is high.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ext_bus_regs.vh"

module external_program_memory_bus (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire [1:0]  MEM_MODE,
  input  wire        EXEC_INTERNAL,
  input  wire        REQ,
  input  wire [1:0]  REQ_KIND,
  input  wire [20:0] REQ_ADDR,
  input  wire [7:0]  TABLE_LATCH,
  output reg         REQ_READY,
  output reg         DONE,
  output reg  [15:0] RDATA,
  input  wire [15:0] AD_IN,
  output reg  [15:0] AD_OUT,
  output reg         AD_OE_N,
  output reg  [3:0]  A_HI_OUT,
  output reg         A_HI_OE_N,
  output reg         ADDR_LATCH,
  output reg         READ_STROBE_N,
  output reg         WRITE_STROBE_HIGH_N,
  output reg         WRITE_STROBE_LOW_N,
  output reg         UPPER_BYTE_ENABLE_N,
  output reg         LOWER_BYTE_ENABLE_N,
  output reg         BYTE_ADDRESS_LSB,
  output reg         PORT_MODE
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_HOLD = 3'h2;
  localparam [2:0] S_RD   = 3'h3;
  localparam [2:0] S_WR   = 3'h4;
  localparam [2:0] S_END  = 3'h5;

  reg  [1:0]  mode_q;
  reg         mode_ok_q;
  reg  [7:0]  bus_config_reg_q;
  reg         off_eff_q;
  reg  [2:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [1:0]  kind_q;
  reg  [20:0] addr_q;
  reg  [15:0] wdata_q;
  reg  [7:0]  low_hold_q;
  reg  [15:0] ad_s1_q;
  reg  [15:0] ad_s2_q;
  reg  [15:0] ad_s3_q;

  wire        mcu;
  wire        mpu;
  wire        apb_do;
  wire        cfg_hit;
  wire        stat_hit;
  wire        external_bus_off;
  wire [1:0]  wait_field;
  wire [1:0]  table_write_style;
  wire [3:0]  tbl_wait;
  wire        accept;
  wire        even_hold;
  wire        busy;
  wire [7:0]  stat_val;

  //////////////////////////////////////////////////////////////////////
  // Mode straps and configuration
  //////////////////////////////////////////////////////////////////////

  // Straps caught once after reset release, never in the reset branch
  always @(posedge CLK) begin
    if (RST) begin
      mode_q    <= `MODE_MCU;
      mode_ok_q <= 1'b0;
    end else if (!mode_ok_q) begin
      mode_q    <= MEM_MODE;
      mode_ok_q <= 1'b1;
    end
  end

  assign mcu = mode_q == `MODE_MCU;
  assign mpu = mode_q == `MODE_MPU;

  assign external_bus_off  = bus_config_reg_q[`CFG_OFF_BIT];
  assign wait_field        = bus_config_reg_q[`CFG_WAIT_HI:`CFG_WAIT_LO];
  assign table_write_style = bus_config_reg_q[`CFG_STYLE_HI:`CFG_STYLE_LO];

  // Inverted code gives the extra cycles: 11 -> 0 ... 00 -> 3
  assign tbl_wait = {2'b00, ~wait_field};

  //////////////////////////////////////////////////////////////////////
  // APB slave
  //////////////////////////////////////////////////////////////////////

  // Access completes on the second access-phase edge
  assign apb_do   = PSEL & PENABLE & PREADY;
  assign cfg_hit  = PADDR == `CFG_OFS;
  assign stat_hit = PADDR == `STAT_OFS;
  assign busy     = state_q != S_IDLE;

  assign stat_val = {2'b00, mode_q, 1'b0, off_eff_q, busy, PORT_MODE};

  // One wait state per access; answer registered
  always @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL & PENABLE & ~PREADY) begin
        PSLVERR <= ~(cfg_hit | stat_hit);
        if (PWRITE | ~(cfg_hit | stat_hit))
          PRDATA <= 32'h0000_0000;
        else if (cfg_hit)
          PRDATA <= {24'h00_0000, bus_config_reg_q};
        else
          PRDATA <= {24'h00_0000, stat_val};
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Config register; internal-only mode pins it at reset value
  always @(posedge CLK) begin
    if (RST) begin
      bus_config_reg_q <= `CFG_RESET;
    end else if (mcu) begin
      bus_config_reg_q <= `CFG_RESET;
    end else if (apb_do & PWRITE & cfg_hit) begin
      bus_config_reg_q <= PWDATA[7:0] & `CFG_MASK;
    end
  end

  // Bus-off only takes hold once code runs internally; clearing
  // is immediate since it can only widen bus availability
  always @(posedge CLK) begin
    if (RST) begin
      off_eff_q <= 1'b0;
    end else if (EXEC_INTERNAL | ~external_bus_off) begin
      off_eff_q <= external_bus_off;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  //////////////////////////////////////////////////////////////////////

  // Three stages; only stage two looks at stage one
  always @(posedge CLK) begin
    if (RST) begin
      ad_s1_q <= 16'h0000;
      ad_s2_q <= 16'h0000;
      ad_s3_q <= 16'h0000;
    end else begin
      ad_s1_q <= AD_IN;
      ad_s2_q <= ad_s1_q;
      ad_s3_q <= ad_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  //////////////////////////////////////////////////////////////////////

  // Even byte in word style is only held, no bus cycle
  assign even_hold = (REQ_KIND == `KIND_TWR) & ~REQ_ADDR[0] &
                     table_write_style[1];
  assign accept    = REQ & REQ_READY;

  // Requests only in modes with external space
  always @(posedge CLK) begin
    if (RST) begin
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      kind_q     <= `KIND_FETCH;
      addr_q     <= 21'h00_0000;
      wdata_q    <= 16'h0000;
      low_hold_q <= 8'h00;
      REQ_READY  <= 1'b0;
      DONE       <= 1'b0;
      RDATA      <= 16'h0000;
    end else begin
      DONE <= 1'b0;
      case (state_q)
        S_IDLE: begin
          REQ_READY <= ~mcu & mode_ok_q & ~accept;
          if (accept & even_hold) begin
            low_hold_q <= TABLE_LATCH;
            DONE       <= 1'b1;
            REQ_READY  <= 1'b0;
            state_q    <= S_END;
          end else if (accept) begin
            kind_q  <= REQ_KIND;
            addr_q  <= REQ_ADDR;
            state_q <= S_ADDR;
            if (table_write_style[1])
              wdata_q <= {TABLE_LATCH, low_hold_q};
            else
              wdata_q <= {TABLE_LATCH, TABLE_LATCH};
          end
        end
        S_ADDR: begin
          state_q <= S_HOLD;
        end
        S_HOLD: begin
          if (kind_q == `KIND_TWR) begin
            cnt_q   <= tbl_wait;
            state_q <= S_WR;
          end else if (kind_q == `KIND_TRD) begin
            cnt_q   <= tbl_wait + `SYNC_LAT;
            state_q <= S_RD;
          end else begin
            cnt_q   <= `SYNC_LAT;
            state_q <= S_RD;
          end
        end
        S_RD: begin
          // Data taken only once two stages agree
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (ad_s2_q == ad_s3_q) begin
            RDATA   <= ad_s3_q;
            DONE    <= 1'b1;
            state_q <= S_END;
          end
        end
        S_WR: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            DONE    <= 1'b1;
            state_q <= S_END;
          end
        end
        S_END: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin drive
  //////////////////////////////////////////////////////////////////////

  // Registered pins; next state decides what each pin shows
  reg [2:0]  nstate_d;
  reg        port_d;
  always @* begin
    nstate_d = state_q;
    if (state_q == S_IDLE & accept & ~even_hold)
      nstate_d = S_ADDR;
    else if (state_q == S_ADDR)
      nstate_d = S_HOLD;
    else if (state_q == S_HOLD)
      nstate_d = (kind_q == `KIND_TWR) ? S_WR : S_RD;
    else if (state_q == S_END)
      nstate_d = S_IDLE;
    else if (state_q == S_RD & cnt_q == 4'h0 & ad_s2_q == ad_s3_q)
      nstate_d = S_END;
    else if (state_q == S_WR & cnt_q == 4'h0)
      nstate_d = S_END;
    // Any external cycle forces the bus function
    port_d = ~(mpu | (nstate_d != S_IDLE) | (~mcu & ~off_eff_q));
  end

  always @(posedge CLK) begin
    if (RST) begin
      PORT_MODE           <= 1'b1;
      AD_OUT              <= 16'h0000;
      AD_OE_N             <= 1'b1;
      A_HI_OUT            <= 4'h0;
      A_HI_OE_N           <= 1'b1;
      ADDR_LATCH          <= 1'b0;
      READ_STROBE_N       <= 1'b1;
      WRITE_STROBE_HIGH_N <= 1'b1;
      WRITE_STROBE_LOW_N  <= 1'b1;
      UPPER_BYTE_ENABLE_N <= 1'b1;
      LOWER_BYTE_ENABLE_N <= 1'b1;
      BYTE_ADDRESS_LSB    <= 1'b0;
    end else begin
      PORT_MODE <= port_d;
      // Idle defaults: lines released, strobes inactive
      AD_OE_N             <= 1'b1;
      A_HI_OE_N           <= 1'b1;
      ADDR_LATCH          <= 1'b0;
      READ_STROBE_N       <= 1'b1;
      WRITE_STROBE_HIGH_N <= 1'b1;
      WRITE_STROBE_LOW_N  <= 1'b1;
      UPPER_BYTE_ENABLE_N <= 1'b1;
      LOWER_BYTE_ENABLE_N <= 1'b1;
      BYTE_ADDRESS_LSB    <= 1'b0;
      case (nstate_d)
        S_ADDR, S_HOLD: begin
          AD_OUT     <= addr_q[16:1];
          AD_OE_N    <= 1'b0;
          A_HI_OUT   <= addr_q[20:17];
          A_HI_OE_N  <= 1'b0;
          ADDR_LATCH <= nstate_d == S_ADDR;
          if (nstate_d == S_ADDR)
            AD_OUT <= REQ_ADDR[16:1];
          if (nstate_d == S_ADDR)
            A_HI_OUT <= REQ_ADDR[20:17];
        end
        S_RD: begin
          A_HI_OUT            <= addr_q[20:17];
          A_HI_OE_N           <= 1'b0;
          READ_STROBE_N       <= 1'b0;
          UPPER_BYTE_ENABLE_N <= 1'b0;
          LOWER_BYTE_ENABLE_N <= 1'b0;
        end
        S_WR: begin
          AD_OUT    <= wdata_q;
          AD_OE_N   <= 1'b0;
          A_HI_OUT  <= addr_q[20:17];
          A_HI_OE_N <= 1'b0;
          if (table_write_style[1]) begin
            WRITE_STROBE_HIGH_N <= 1'b0;
          end else if (table_write_style == `STYLE_BYTE_SEL) begin
            WRITE_STROBE_HIGH_N <= 1'b0;
            UPPER_BYTE_ENABLE_N <= ~addr_q[0];
            LOWER_BYTE_ENABLE_N <= addr_q[0];
            BYTE_ADDRESS_LSB    <= addr_q[0];
          end else begin
            WRITE_STROBE_HIGH_N <= ~addr_q[0];
            WRITE_STROBE_LOW_N  <= addr_q[0];
          end
        end
        S_END: begin
          // Data held one cycle past strobe release
          AD_OE_N   <= ~(kind_q == `KIND_TWR & state_q == S_WR);
          A_HI_OE_N <= 1'b0;
        end
        default: begin
          AD_OE_N <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== dv/ext_bus_monitor.sv ====
// Checker for the external program memory bus, bound to its top.
// Assumes MEM_MODE stays steady from one reset to the next.
`timescale 1ns/1ps
module ext_bus_monitor (
  input logic        CLK,
  input logic        RST,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic [1:0]  MEM_MODE,
  input logic        REQ,
  input logic        REQ_READY,
  input logic        DONE,
  input logic [15:0] AD_OUT,
  input logic        AD_OE_N,
  input logic        A_HI_OE_N,
  input logic        ADDR_LATCH,
  input logic        READ_STROBE_N,
  input logic        WRITE_STROBE_HIGH_N,
  input logic        WRITE_STROBE_LOW_N,
  input logic        UPPER_BYTE_ENABLE_N,
  input logic        LOWER_BYTE_ENABLE_N,
  input logic        BYTE_ADDRESS_LSB,
  input logic        PORT_MODE
);
  logic [1:0] up_q; // Edges since release, saturating
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Mode caught one edge after release, pins one edge later, so wait three
  always @(posedge CLK) begin
    if (RST) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  idle_bus_a: assert property (
    REQ_READY |-> AD_OE_N && A_HI_OE_N && READ_STROBE_N && !ADDR_LATCH
      && WRITE_STROBE_HIGH_N && WRITE_STROBE_LOW_N && !BYTE_ADDRESS_LSB
      && UPPER_BYTE_ENABLE_N && LOWER_BYTE_ENABLE_N)
    else $error("idle bus not released");
  latch_drive_a: assert property (
    $rose(ADDR_LATCH) |-> !AD_OE_N && !A_HI_OE_N ##1 !ADDR_LATCH)
    else $error("address latch strobe wrong");
  read_order_a: assert property (
    $fell(READ_STROBE_N) |-> $past(ADDR_LATCH, 2) && AD_OE_N
      && !UPPER_BYTE_ENABLE_N && !LOWER_BYTE_ENABLE_N)
    else $error("read strobe out of order");
  pins_busy_a: assert property (
    ADDR_LATCH || !READ_STROBE_N || !WRITE_STROBE_HIGH_N
      || !WRITE_STROBE_LOW_N |-> !PORT_MODE)
    else $error("port function during access");
  done_soon_a: assert property (
    REQ && REQ_READY |-> ##[1:16] DONE)
    else $error("access never finished");
  ext_only_a: assert property (
    up_q == 2'h3 && MEM_MODE == 2'h0 |-> !PORT_MODE)
    else $error("port function in external mode");
  int_only_a: assert property (
    up_q == 2'h3 && MEM_MODE == 2'h3 |-> PORT_MODE && !REQ_READY && AD_OE_N)
    else $error("bus active in internal mode");
  cfg_held_a: assert property (
    up_q == 2'h3 && MEM_MODE == 2'h3 && PREADY && !PWRITE
      && PADDR == 12'h000 |-> PRDATA == 32'h0)
    else $error("config left reset state");
  byte_copy_a: assert property (
    !WRITE_STROBE_LOW_N |-> !AD_OE_N && AD_OUT[15:8] == AD_OUT[7:0])
    else $error("byte not on both halves");
  cover property ($fell(READ_STROBE_N));
  cover property (!WRITE_STROBE_LOW_N);
  cover property ($rose(PORT_MODE) && up_q == 2'h3);
endmodule
bind external_program_memory_bus ext_bus_monitor i_ext_bus_monitor (.*);

// ==== dv/ext_mem_model.sv ====
// Behavioural 16-bit external memory: answers reads, logs writes.
// Assumes the bus pins of the block and its single clock.
`timescale 1ns/1ps
module ext_mem_model (
  input  logic        CLK,
  input  logic [15:0] AD_OUT,
  input  logic        ADDR_LATCH,
  input  logic        READ_STROBE_N,
  input  logic        WRITE_STROBE_HIGH_N,
  input  logic        WRITE_STROBE_LOW_N,
  input  logic        UPPER_BYTE_ENABLE_N,
  input  logic        LOWER_BYTE_ENABLE_N,
  input  logic        BYTE_ADDRESS_LSB,
  output logic [15:0] AD_IN,
  output logic [4:0]  wr_ctl,
  output logic [15:0] wr_data
);
  logic [15:0] addr_q;
  logic [15:0] last_q = 16'h0;
  logic [15:0] word;
  ////////////////////////////////////////
  // Fixed pattern contents, so the bench can predict them
  assign word = {addr_q[7:0] ^ 8'h5a, addr_q[7:0]};
  // Both bytes at once; released lines show the inverse so a late
  // sample cannot match by chance
  assign AD_IN = !READ_STROBE_N ? word : ~last_q;
  // Latch the address, log strobes and byte enables of each write
  always @(posedge CLK) begin
    if (ADDR_LATCH) addr_q <= AD_OUT;
    if (!READ_STROBE_N) last_q <= word;
    if (!WRITE_STROBE_HIGH_N || !WRITE_STROBE_LOW_N) begin
      // Byte line logged too: byte-wide flash steers on it
      wr_ctl <= {WRITE_STROBE_HIGH_N, WRITE_STROBE_LOW_N,
                 UPPER_BYTE_ENABLE_N, LOWER_BYTE_ENABLE_N,
                 BYTE_ADDRESS_LSB};
      wr_data <= AD_OUT;
    end
  end
endmodule

// ==== dv/test_external_program_memory_bus.sv ====
// Self-checking bench for the external program memory bus.
// Assumes the design, its bound checker and the memory model.
`timescale 1ns/1ps
module test_external_program_memory_bus;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [1:0]  MEM_MODE, REQ_KIND;
  logic        EXEC_INTERNAL, REQ, REQ_READY, DONE, AD_OE_N, A_HI_OE_N;
  logic [20:0] REQ_ADDR;
  logic [7:0]  TABLE_LATCH, i;
  logic [15:0] RDATA, AD_IN, AD_OUT, wr_data;
  logic [3:0]  A_HI_OUT;
  logic [4:0]  wr_ctl;
  logic        ADDR_LATCH, READ_STROBE_N, WRITE_STROBE_HIGH_N;
  logic        WRITE_STROBE_LOW_N, UPPER_BYTE_ENABLE_N, LOWER_BYTE_ENABLE_N;
  logic        BYTE_ADDRESS_LSB, PORT_MODE;
  int          errors, n_tests, lat;
  external_program_memory_bus i_external_program_memory_bus (.*);
  ext_mem_model i_ext_mem_model (.*);
  ////////////////////////////////////////
  // 25 MHz clock
  initial begin
    CLK = 0;
    forever #20 CLK = ~CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Every wait is bounded; running out ends the run
  task automatic step(inout int k);
    @(posedge CLK);
    k++;
    if (k > 50) begin
      errors++;
      summarize;
    end
  endtask
  task automatic reset(input logic [1:0] mode);
    @(posedge CLK);
    RST <= 1;
    MEM_MODE <= mode;
    repeat (8) @(posedge CLK);
    RST <= 0;
    repeat (3) @(posedge CLK);
  endtask
  // APB transfer held until PREADY is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, exp, input logic err);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do step(k); while (PREADY !== 1'b1);
    if (!wr) check(PRDATA, exp);
    check(PSLVERR, err);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // Core access: wait for ready, then count edges up to DONE
  task automatic access(input logic [1:0] kind, input logic [20:0] a,
                        input logic [7:0] tl, input int exp_lat);
    int k;
    k = 0;
    @(posedge CLK);
    REQ <= 1;
    REQ_KIND <= kind;
    REQ_ADDR <= a;
    TABLE_LATCH <= tl;
    do step(k); while (REQ_READY !== 1'b1);
    REQ <= 0;
    lat = 0;
    do step(lat); while (DONE !== 1'b1);
    check(lat, exp_lat);
  endtask
  initial begin
    RST = 1;
    {PSEL, PENABLE, PWRITE, REQ} = 4'h0;
    {PADDR, PWDATA, REQ_ADDR, TABLE_LATCH} = 0;
    MEM_MODE = 2'h2;
    REQ_KIND = 2'h0;
    EXEC_INTERNAL = 1;
    reset(2'h2);
    apb(0, 12'h000, 0, 32'h0, 0);
    apb(1, 12'h000, 32'hff, 0, 0);
    apb(0, 12'h000, 0, 32'hb3, 0);
    apb(0, 12'h008, 0, 32'h0, 1);
    check(PORT_MODE, 1);
    apb(1, 12'h000, 32'h30, 0, 0);
    // Effective bit, then pin register: two edges before it shows
    repeat (3) @(posedge CLK);
    check(PORT_MODE, 0);
    $display("test registers done");
    // Every wait code, reads and byte writes on both strobes
    for (int w = 0; w < 4; w++) begin
      apb(1, 12'h000, (3 - w) * 16, 0, 0);
      i = 8'h82 + w;
      access(2'h1, 21'h000104 + w * 2, 8'h0, 7 + w);
      check(RDATA, {i ^ 8'h5a, i});
      access(2'h2, 21'h000300 + w, 8'h3c, 4 + w);
      check(wr_ctl[4:3], w[0] ? 2'b01 : 2'b10);
      check(wr_data, 16'h3c3c);
    end
    access(2'h0, 21'h000020, 8'h0, 7);
    check(RDATA, 16'h4a10);
    $display("test wait codes done");
    apb(1, 12'h000, 32'h31, 0, 0);
    for (int b = 0; b < 2; b++) begin
      access(2'h2, 21'h000300 + b, 8'h77, 4);
      check(wr_ctl, b ? 5'b01011 : 5'b01100);
      check(wr_data, 16'h7777);
    end
    apb(1, 12'h000, 32'h32, 0, 0);
    access(2'h2, 21'h000300, 8'h11, 1);
    access(2'h2, 21'h000301, 8'h22, 4);
    check(wr_ctl[4:3], 2'b01);
    check(wr_data, 16'h2211);
    $display("test write styles done");
    // Bus-off set from external code waits for internal execution
    EXEC_INTERNAL <= 0;
    apb(1, 12'h000, 32'hb0, 0, 0);
    // Long enough that an undeferred bit would already show
    repeat (4) @(posedge CLK);
    check(PORT_MODE, 0);
    EXEC_INTERNAL <= 1;
    lat = 0;
    do step(lat); while (PORT_MODE !== 1'b1);
    access(2'h0, 21'h000020, 8'h0, 7);
    check(RDATA, 16'h4a10);
    repeat (3) @(posedge CLK);
    check(PORT_MODE, 1);
    apb(0, 12'h004, 0, 32'h25, 0);
    $display("test bus off done");
    reset(2'h3);
    check(PORT_MODE, 1);
    check(REQ_READY, 0);
    apb(1, 12'h000, 32'h30, 0, 0);
    apb(0, 12'h000, 0, 32'h0, 0);
    reset(2'h0);
    apb(1, 12'h000, 32'hb0, 0, 0);
    repeat (3) @(posedge CLK);
    check(PORT_MODE, 0);
    // Kind code 11 must act as a fetch; upper lines carry address
    access(2'h3, 21'h1e0020, 8'h0, 7);
    check(RDATA, 16'h4a10);
    check(A_HI_OUT, 4'hf);
    apb(0, 12'h004, 0, 32'h04, 0);
    $display("test modes done");
    summarize;
  end
endmodule
